// >>> hdl/lmp_top.sv
// duty store, configuration, fault flags and scan sequencer of the matrix driver
`timescale 1ns/1ns
`default_nettype none
module lmp_top #(
	parameter int SCAN_CYCLES = lmp_pkg::SCAN_CYC
) (
	input wire logic clk_sys,
	input wire logic resetn,
	input wire logic reg_wr_en,
	input wire logic reg_rd_en,
	input wire logic reg_page,
	input wire logic [7:0] reg_addr,
	input wire logic [7:0] reg_wdata,
	output logic [7:0] reg_rdata,
	output logic reg_rvalid,
	input wire logic over_temp_in,
	input wire logic over_current_in,
	input wire logic led_short_in,
	input wire logic led_open_in,
	input wire logic open_short_det_en,
	output logic soft_shutdown_n,
	output logic [8:0] scan_line_on,
	output logic [47:0] sink_channel_on,
	output logic [47:0] sink_deghost,
	output logic [47:0][7:0] sink_current_scale
);
	localparam logic [lmp_pkg::CNT_W-1:0] SCAN_LAST = lmp_pkg::CNT_W'(SCAN_CYCLES - 1);
	localparam logic [lmp_pkg::CNT_W-1:0] NOL_LAST = lmp_pkg::CNT_W'(lmp_pkg::NOL_CYC - 1);
	localparam logic [lmp_pkg::CNT_W-1:0] DLY_LAST = lmp_pkg::CNT_W'(lmp_pkg::CHDLY_CYC - 1);
	localparam logic [3:0] LAST_LINE = 4'(lmp_pkg::NUM_LINES - 1);
	localparam logic [3:0] PG1_LINE = 4'(lmp_pkg::PG1_FIRST_LINE);

	lmp_pkg::lmp_st_s st_r;
	lmp_pkg::lmp_st_s st_nxt;
	logic [3:0] sel;
	logic [8:0] line_mask;
	logic [5:0] ch_limit;

	lmp_pwm_if pwm_if ();

	// lines taken part in the scan for each select code
	function automatic logic [8:0] scan_mask(input logic [3:0] code);
		logic [8:0] m;
		m = '0;
		if (code <= lmp_pkg::SEL_TWO) begin
			for (int i = 0; i < lmp_pkg::NUM_LINES; i++) begin
				m[i] = (i < (lmp_pkg::NUM_LINES - int'(code)));
			end
		end else begin
			case (code)
				lmp_pkg::SEL_47X1: m = 9'h001;
				lmp_pkg::SEL_ODD4: m = 9'h055;
				lmp_pkg::SEL_ODD3: m = 9'h015;
				lmp_pkg::SEL_ODD2: m = 9'h005;
				default: m = 9'h000;
			endcase
		end
		return m;
	endfunction : scan_mask

	// highest usable channel; shared pins above it drive the scan gates
	function automatic logic [5:0] chan_limit(input logic [3:0] code);
		logic [5:0] lim;
		case (code)
			lmp_pkg::SEL_NINE: lim = lmp_pkg::CH_DIRECT;
			lmp_pkg::SEL_47X1: lim = 6'h2F;
			lmp_pkg::SEL_ODD4: lim = 6'h29;
			lmp_pkg::SEL_ODD3: lim = 6'h2B;
			lmp_pkg::SEL_ODD2: lim = 6'h2D;
			lmp_pkg::SEL_DIRECT: lim = 6'h30;
			default: lim = 6'((lmp_pkg::NUM_CH - lmp_pkg::NUM_LINES) + int'(code));
		endcase
		return lim;
	endfunction : chan_limit

	// next scan line after the current one, wrapping round
	function automatic logic [3:0] next_line(input logic [8:0] m, input logic [3:0] cur);
		logic [3:0] nl;
		logic found;
		int idx;
		nl = '0;
		found = 1'b0;
		for (int k = 1; k <= lmp_pkg::NUM_LINES; k++) begin
			idx = (int'(cur) + k) % lmp_pkg::NUM_LINES;
			if (!found && m[idx]) begin
				nl = 4'(idx);
				found = 1'b1;
			end
		end
		return nl;
	endfunction : next_line

	// duty byte of a dot: line index 0..8, channel 1..48
	function automatic logic [7:0] duty_of(input lmp_pkg::lmp_st_s s, input logic [3:0] line,
		input logic [5:0] ch);
		logic pg1;
		logic [7:0] lr;
		logic [7:0] addr;
		logic [7:0] byte_v;
		pg1 = (line >= PG1_LINE);
		lr = pg1 ? 8'(line - PG1_LINE) : 8'(line);
		if (ch <= lmp_pkg::CH_DIRECT) begin
			addr = 8'(lr * lmp_pkg::COL_STRIDE) + 8'(ch);
		end else begin
			addr = (pg1 ? lmp_pkg::PG1_EXT_BASE : lmp_pkg::PG0_EXT_BASE) +
				8'(lr * lmp_pkg::EXT_STRIDE) + 8'(ch - lmp_pkg::CH_DIRECT);
		end
		byte_v = '0;
		if (!pg1 && addr >= lmp_pkg::DUTY_FIRST && addr <= lmp_pkg::PG0_DUTY_LAST) begin
			byte_v = s.duty0[addr - lmp_pkg::DUTY_FIRST];
		end else if (pg1 && addr >= lmp_pkg::DUTY_FIRST && addr <= lmp_pkg::PG1_DUTY_LAST) begin
			byte_v = s.duty1[addr - lmp_pkg::DUTY_FIRST];
		end
		return byte_v;
	endfunction : duty_of

	assign sel = st_r.config_r[lmp_pkg::CFG_SEL_HI:lmp_pkg::CFG_SEL_LO];
	assign line_mask = scan_mask(sel);
	assign ch_limit = chan_limit(sel);

	// next state: registers, fault capture, scan sequencer
	always_comb begin
		logic [7:0] rd_v;
		logic do_reset;
		logic [lmp_pkg::FAULT_W-1:0] ev;
		rd_v = '0;
		do_reset = 1'b0;
		ev = '0;
		st_nxt = st_r;

		// pins pass two flops; the second stage alone feeds the flags
		st_nxt.sync1_r = {open_short_det_en, over_temp_in, over_current_in, led_short_in, led_open_in};
		st_nxt.sync2_r = st_r.sync1_r;
		ev[lmp_pkg::FLT_OT] = st_r.sync2_r[lmp_pkg::FLT_OT];
		ev[lmp_pkg::FLT_OC] = st_r.sync2_r[lmp_pkg::FLT_OC];
		ev[lmp_pkg::FLT_SHORT] = st_r.sync2_r[lmp_pkg::FLT_SHORT];
		ev[lmp_pkg::FLT_OPEN] = st_r.sync2_r[lmp_pkg::FLT_OPEN] &&
			st_r.sync2_r[lmp_pkg::FAULT_W];

		// register writes, page picked by the serial side
		if (reg_wr_en) begin
			if (!reg_page) begin
				if (reg_addr >= lmp_pkg::DUTY_FIRST && reg_addr <= lmp_pkg::PG0_DUTY_LAST) begin
					st_nxt.duty0[reg_addr - lmp_pkg::DUTY_FIRST] = reg_wdata;
				end else begin
					case (reg_addr)
						lmp_pkg::ADDR_CONFIG: st_nxt.config_r = reg_wdata;
						lmp_pkg::ADDR_RED_SCALE: st_nxt.red_r = reg_wdata;
						lmp_pkg::ADDR_GREEN_SCALE: st_nxt.green_r = reg_wdata;
						lmp_pkg::ADDR_BLUE_SCALE: st_nxt.blue_r = reg_wdata;
						default: ;
					endcase
				end
			end else begin
				if (reg_addr >= lmp_pkg::DUTY_FIRST && reg_addr <= lmp_pkg::PG1_DUTY_LAST) begin
					st_nxt.duty1[reg_addr - lmp_pkg::DUTY_FIRST] = reg_wdata;
				end else if (reg_addr == lmp_pkg::ADDR_SOFT_RESET) begin
					do_reset = st_r.config_r[lmp_pkg::CFG_UNLOCK];
				end
			end
		end

		// register reads; fault flags clear on read
		st_nxt.rvalid_r = reg_rd_en;
		if (reg_rd_en) begin
			if (!reg_page) begin
				if (reg_addr >= lmp_pkg::DUTY_FIRST && reg_addr <= lmp_pkg::PG0_DUTY_LAST) begin
					rd_v = st_r.duty0[reg_addr - lmp_pkg::DUTY_FIRST];
				end else begin
					case (reg_addr)
						lmp_pkg::ADDR_FAULT: rd_v = {4'h0, st_r.fault_r};
						lmp_pkg::ADDR_CONFIG: rd_v = st_r.config_r;
						lmp_pkg::ADDR_RED_SCALE: rd_v = st_r.red_r;
						lmp_pkg::ADDR_GREEN_SCALE: rd_v = st_r.green_r;
						lmp_pkg::ADDR_BLUE_SCALE: rd_v = st_r.blue_r;
						default: rd_v = '0;
					endcase
				end
				if (reg_addr == lmp_pkg::ADDR_FAULT) begin
					st_nxt.fault_r = '0;
				end
			end else if (reg_addr >= lmp_pkg::DUTY_FIRST && reg_addr <= lmp_pkg::PG1_DUTY_LAST) begin
				rd_v = st_r.duty1[reg_addr - lmp_pkg::DUTY_FIRST];
			end
			st_nxt.rdata_r = rd_v;
		end
		// a fault in the clearing cycle survives the clear
		st_nxt.fault_r = st_nxt.fault_r | ev;

		// scan sequencer
		case (st_r.slot_r)
			lmp_pkg::SLOT_OFF: begin
				if (st_r.config_r[lmp_pkg::CFG_SSD]) begin
					st_nxt.slot_r = lmp_pkg::SLOT_ACTIVE;
					st_nxt.cnt_r = '0;
					st_nxt.pwm_r = '0;
					st_nxt.frame_r = '0;
					st_nxt.line_r = next_line(line_mask, LAST_LINE);
				end
			end
			lmp_pkg::SLOT_ACTIVE: begin
				st_nxt.cnt_r = st_r.cnt_r + 1'b1;
				if (st_r.config_r[lmp_pkg::CFG_RES]) begin
					st_nxt.pwm_r = st_r.pwm_r + 1'b1;
				end else if (st_r.pwm_r[5:0] == lmp_pkg::DITHER_TOP) begin
					st_nxt.pwm_r = '0;
					st_nxt.frame_r = st_r.frame_r + 1'b1;
				end else begin
					st_nxt.pwm_r = {2'h0, st_r.pwm_r[5:0] + 6'h01};
				end
				if (st_r.cnt_r == SCAN_LAST) begin
					st_nxt.slot_r = lmp_pkg::SLOT_NOL;
					st_nxt.cnt_r = '0;
				end
			end
			lmp_pkg::SLOT_NOL: begin
				st_nxt.cnt_r = st_r.cnt_r + 1'b1;
				if (st_r.cnt_r == NOL_LAST) begin
					st_nxt.slot_r = lmp_pkg::SLOT_DELAY;
					st_nxt.cnt_r = '0;
				end
			end
			lmp_pkg::SLOT_DELAY: begin
				st_nxt.cnt_r = st_r.cnt_r + 1'b1;
				if (st_r.cnt_r == DLY_LAST) begin
					st_nxt.slot_r = lmp_pkg::SLOT_ACTIVE;
					st_nxt.cnt_r = '0;
					st_nxt.pwm_r = '0;
					st_nxt.line_r = next_line(line_mask, st_r.line_r);
				end
			end
			default: st_nxt.slot_r = lmp_pkg::SLOT_OFF;
		endcase
		// shutdown overrides any slot
		if (!st_r.config_r[lmp_pkg::CFG_SSD]) begin
			st_nxt.slot_r = lmp_pkg::SLOT_OFF;
			st_nxt.cnt_r = '0;
		end

		// soft reset: every register back to default, pins keep syncing
		if (do_reset) begin
			st_nxt.duty0 = '0;
			st_nxt.duty1 = '0;
			st_nxt.config_r = lmp_pkg::REG_RESET;
			st_nxt.red_r = lmp_pkg::REG_RESET;
			st_nxt.green_r = lmp_pkg::REG_RESET;
			st_nxt.blue_r = lmp_pkg::REG_RESET;
			st_nxt.fault_r = '0;
			st_nxt.slot_r = lmp_pkg::SLOT_OFF;
			st_nxt.cnt_r = '0;
		end

		// gate drive: only during the active part, never in direct mode
		st_nxt.scan_on_r = '0;
		if (st_nxt.slot_r == lmp_pkg::SLOT_ACTIVE) begin
			st_nxt.scan_on_r = line_mask & (9'h001 << st_nxt.line_r);
		end
	end

	always_ff @(posedge clk_sys or negedge resetn) begin
		if (!resetn) begin
			st_r <= '0;
			st_r.slot_r <= lmp_pkg::SLOT_OFF;
		end else begin
			st_r <= st_nxt;
		end
	end

	// shared timing to the channel slices
	assign pwm_if.pwm_cnt = st_r.pwm_r;
	assign pwm_if.frame = st_r.frame_r;
	assign pwm_if.res_8bit = st_r.config_r[lmp_pkg::CFG_RES];
	assign pwm_if.active = (st_r.slot_r == lmp_pkg::SLOT_ACTIVE);
	assign pwm_if.nol = (st_r.slot_r == lmp_pkg::SLOT_NOL);
	assign pwm_if.deghost_timing_select = st_r.config_r[lmp_pkg::CFG_DEG];

	// one slice per sink channel; colour group by channel modulo three
	for (genvar g = 0; g < lmp_pkg::NUM_CH; g++) begin : g_ch
		logic [7:0] duty_g;
		logic [7:0] scale_g;
		logic en_g;
		assign duty_g = duty_of(st_r, (sel == lmp_pkg::SEL_DIRECT) ? 4'h0 : st_r.line_r, 6'(g + 1));
		assign en_g = (6'(g + 1) <= ch_limit);
		assign scale_g = (g % 3 == 0) ? st_r.red_r : ((g % 3 == 1) ? st_r.green_r : st_r.blue_r);
		lmp_ch_slice u_slice (
			.clk_sys(clk_sys),
			.resetn(resetn),
			.pwm(pwm_if.sink),
			.duty(duty_g),
			.ch_en(en_g),
			.scale_in(scale_g),
			.on_out(sink_channel_on[g]),
			.deghost_out(sink_deghost[g]),
			.scale_out(sink_current_scale[g])
		);
	end

	assign reg_rdata = st_r.rdata_r;
	assign reg_rvalid = st_r.rvalid_r;
	assign soft_shutdown_n = st_r.config_r[lmp_pkg::CFG_SSD];
	assign scan_line_on = st_r.scan_on_r;
endmodule : lmp_top
`default_nettype wire

// >>> inc/lmp_pkg.sv
// shared constants, types and state layout for the led matrix pwm block
package lmp_pkg;

	// array geometry
	localparam int NUM_CH = 48;
	localparam int NUM_LINES = 9;
	localparam int PG0_DEPTH = 236;
	localparam int PG1_DEPTH = 177;
	localparam int PG1_FIRST_LINE = 5;

	// register map
	localparam logic [7:0] DUTY_FIRST = 8'h01;
	localparam logic [7:0] PG0_DUTY_LAST = 8'hEC;
	localparam logic [7:0] PG1_DUTY_LAST = 8'hB1;
	localparam logic [7:0] ADDR_FAULT = 8'hEF;
	localparam logic [7:0] ADDR_CONFIG = 8'hF0;
	localparam logic [7:0] ADDR_RED_SCALE = 8'hF1;
	localparam logic [7:0] ADDR_GREEN_SCALE = 8'hF2;
	localparam logic [7:0] ADDR_BLUE_SCALE = 8'hF3;
	localparam logic [7:0] ADDR_SOFT_RESET = 8'hFF;
	localparam logic [7:0] REG_RESET = 8'h00;

	// duty map layout: column stride, corner blocks for the shared scan pins
	localparam logic [7:0] COL_STRIDE = 8'h28;
	localparam logic [7:0] PG0_EXT_BASE = 8'hC8;
	localparam logic [7:0] PG1_EXT_BASE = 8'hA0;
	localparam logic [7:0] EXT_STRIDE = 8'h08;
	localparam logic [5:0] CH_DIRECT = 6'h28;

	// operating_config fields
	localparam int CFG_SEL_HI = 7;
	localparam int CFG_SEL_LO = 4;
	localparam int CFG_UNLOCK = 3;
	localparam int CFG_RES = 2;
	localparam int CFG_DEG = 1;
	localparam int CFG_SSD = 0;

	// fault_flags fields
	localparam int FAULT_W = 4;
	localparam int FLT_OT = 3;
	localparam int FLT_OC = 2;
	localparam int FLT_SHORT = 1;
	localparam int FLT_OPEN = 0;

	// scan_line_select codes
	localparam logic [3:0] SEL_NINE = 4'h0;
	localparam logic [3:0] SEL_TWO = 4'h7;
	localparam logic [3:0] SEL_47X1 = 4'h8;
	localparam logic [3:0] SEL_ODD4 = 4'h9;
	localparam logic [3:0] SEL_ODD3 = 4'hA;
	localparam logic [3:0] SEL_ODD2 = 4'hB;
	localparam logic [3:0] SEL_DIRECT = 4'hC;

	// scan slot timing in picoseconds, clock at 250 MHz
	localparam int CLK_PS = 4000;
	localparam int T_SCAN_PS = 113000000;
	localparam int T_NOL_PS = 7700000;
	localparam int T_CHDLY_PS = 20000;
	localparam int SCAN_CYC = (T_SCAN_PS + CLK_PS - 1) / CLK_PS;
	localparam int NOL_CYC = (T_NOL_PS + CLK_PS - 1) / CLK_PS;
	localparam int CHDLY_CYC = (T_CHDLY_PS + CLK_PS - 1) / CLK_PS;
	localparam int CNT_W = 15;
	localparam logic [5:0] DITHER_TOP = 6'h3F;

	typedef enum logic [3:0] {
		SLOT_OFF = 4'b0001,
		SLOT_ACTIVE = 4'b0010,
		SLOT_NOL = 4'b0100,
		SLOT_DELAY = 4'b1000
	} lmp_slot_e;

	typedef struct packed {
		logic [PG0_DEPTH-1:0][7:0] duty0;
		logic [PG1_DEPTH-1:0][7:0] duty1;
		logic [7:0] config_r;
		logic [7:0] red_r;
		logic [7:0] green_r;
		logic [7:0] blue_r;
		logic [FAULT_W-1:0] fault_r;
		logic [FAULT_W:0] sync1_r;
		logic [FAULT_W:0] sync2_r;
		lmp_slot_e slot_r;
		logic [CNT_W-1:0] cnt_r;
		logic [3:0] line_r;
		logic [7:0] pwm_r;
		logic [1:0] frame_r;
		logic [NUM_LINES-1:0] scan_on_r;
		logic [7:0] rdata_r;
		logic rvalid_r;
	} lmp_st_s;

	typedef struct packed {
		logic on_r;
		logic deghost_r;
		logic [7:0] scale_r;
	} lmp_ch_s;

endpackage : lmp_pkg

// >>> inc/lmp_pwm_if.sv
// timing bus from the scan sequencer to the per-channel slices
`timescale 1ns/1ns
`default_nettype none
interface lmp_pwm_if;
	logic [7:0] pwm_cnt;
	logic [1:0] frame;
	logic res_8bit;
	logic active;
	logic nol;
	logic deghost_timing_select;
	modport src (output pwm_cnt, output frame, output res_8bit, output active, output nol, output deghost_timing_select);
	modport sink (input pwm_cnt, input frame, input res_8bit, input active, input nol, input deghost_timing_select);
endinterface : lmp_pwm_if
`default_nettype wire

// >>> hdl/lmp_ch_slice.sv
// one sink channel: duty compare, dithering and de-ghost drive
`timescale 1ns/1ns
`default_nettype none
module lmp_ch_slice (
	input wire logic clk_sys,
	input wire logic resetn,
	lmp_pwm_if.sink pwm,
	input wire logic [7:0] duty,
	input wire logic ch_en,
	input wire logic [7:0] scale_in,
	output logic on_out,
	output logic deghost_out,
	output logic [7:0] scale_out
);
	lmp_pkg::lmp_ch_s st_r;
	lmp_pkg::lmp_ch_s st_nxt;
	logic hit;

	// compare against the running step counter
	always_comb begin
		st_nxt = st_r;
		if (pwm.res_8bit) begin
			hit = (pwm.pwm_cnt < duty);
		end else begin
			// low two duty bits add one extra step in that many of four frames
			hit = (pwm.pwm_cnt[5:0] < duty[7:2]) ||
				((pwm.pwm_cnt[5:0] == duty[7:2]) && (pwm.frame < duty[1:0]));
		end
		st_nxt.on_r = pwm.active && ch_en && hit;
		if (pwm.deghost_timing_select) begin
			st_nxt.deghost_r = pwm.active && ch_en && !hit;
		end else begin
			st_nxt.deghost_r = pwm.nol;
		end
		st_nxt.scale_r = scale_in;
	end

	always_ff @(posedge clk_sys or negedge resetn) begin
		if (!resetn) begin
			st_r <= '0;
		end else begin
			st_r <= st_nxt;
		end
	end

	assign on_out = st_r.on_r;
	assign deghost_out = st_r.deghost_r;
	assign scale_out = st_r.scale_r;
endmodule : lmp_ch_slice
`default_nettype wire

// >>> verif/lmp_host.sv
// host model driving the register port of the matrix driver
`timescale 1ns/1ns
`default_nettype none
module lmp_host (
	input wire logic clk_sys,
	output logic reg_wr_en,
	output logic reg_rd_en,
	output logic reg_page,
	output logic [7:0] reg_addr,
	output logic [7:0] reg_wdata,
	input wire logic [7:0] reg_rdata,
	input wire logic reg_rvalid
);
	// idle bus with both strobes low from time zero
	initial begin
		reg_wr_en = 1'b0;
		reg_rd_en = 1'b0;
		reg_page = 1'b0;
		reg_addr = 8'h00;
		reg_wdata = 8'h00;
	end
	// one write, page travels with the strobe
	task wr(input logic p, input logic [7:0] a, input logic [7:0] d);
		@(posedge clk_sys);
		reg_wr_en <= 1'b1;
		reg_page <= p;
		reg_addr <= a;
		reg_wdata <= d;
		@(posedge clk_sys);
		reg_wr_en <= 1'b0;
		// released lines flip so a stale value never passes
		reg_addr <= ~a;
		reg_wdata <= ~d;
	endtask : wr
	// one read, data taken at the edge that sees the answer
	task rd(input logic p, input logic [7:0] a, output logic [7:0] d);
		@(posedge clk_sys);
		reg_rd_en <= 1'b1;
		reg_page <= p;
		reg_addr <= a;
		@(posedge clk_sys);
		reg_rd_en <= 1'b0;
		reg_addr <= ~a;
		@(posedge clk_sys);
		d = reg_rvalid ? reg_rdata : 8'hXX;
	endtask : rd
endmodule : lmp_host
`default_nettype wire

// >>> verif/lmp_monitor.sv
// concurrent checks on the matrix driver ports
`timescale 1ns/1ns
`default_nettype none
module lmp_monitor #(
	parameter int SCAN_CYCLES = 20
) (
	input wire logic clk_sys,
	input wire logic resetn,
	input wire logic reg_wr_en,
	input wire logic reg_rd_en,
	input wire logic reg_page,
	input wire logic [7:0] reg_addr,
	input wire logic [7:0] reg_wdata,
	input wire logic [7:0] reg_rdata,
	input wire logic reg_rvalid,
	input wire logic over_temp_in,
	input wire logic soft_shutdown_n,
	input wire logic [8:0] scan_line_on,
	input wire logic [47:0][7:0] sink_current_scale
);
	default clocking cb @(posedge clk_sys); endclocking
	default disable iff (!resetn);
	logic flt_rd;
	int act_cnt;
	// read of the fault register
	assign flt_rd = reg_rd_en && !reg_page && reg_addr == lmp_pkg::ADDR_FAULT;
	// length of the current active slot
	always_ff @(posedge clk_sys or negedge resetn) begin
		if (!resetn)
			act_cnt <= 0;
		else
			act_cnt <= (|scan_line_on) ? act_cnt + 1 : 0;
	end
	chk_read_answer: assert property (reg_rd_en |=> reg_rvalid) else $error("read unanswered");
	chk_no_stray: assert property (!reg_rd_en |=> !reg_rvalid) else $error("stray answer");
	chk_shutdown_bit: assert property (reg_wr_en && !reg_page && reg_addr == lmp_pkg::ADDR_CONFIG
		|=> soft_shutdown_n == $past(reg_wdata[0])) else $error("shutdown bit wrong");
	chk_dark_off: assert property (!soft_shutdown_n [*3] |-> scan_line_on == 9'h000) else $error("lit in shutdown");
	chk_one_line: assert property ($onehot0(scan_line_on)) else $error("two lines on");
	chk_slot_len: assert property ($fell(|scan_line_on) && soft_shutdown_n |-> act_cnt == SCAN_CYCLES)
		else $error("active slot length");
	chk_gap_dark: assert property ($fell(|scan_line_on) && soft_shutdown_n |-> (scan_line_on == 9'h000) [*8])
		else $error("no gap");
	chk_temp_flag: assert property (flt_rd && $past(over_temp_in, 3) |=> reg_rdata[lmp_pkg::FLT_OT])
		else $error("temp flag lost");
	chk_fault_upper: assert property (flt_rd |=> reg_rdata[7:4] == 4'h0) else $error("fault upper bits");
	chk_group_scale: assert property (sink_current_scale[0] == sink_current_scale[45]
		&& sink_current_scale[1] == sink_current_scale[46] && sink_current_scale[2] == sink_current_scale[47])
		else $error("group scale differs");
endmodule : lmp_monitor
bind lmp_top lmp_monitor #(.SCAN_CYCLES(SCAN_CYCLES)) mon_u (.clk_sys(clk_sys), .resetn(resetn),
	.reg_wr_en(reg_wr_en), .reg_rd_en(reg_rd_en), .reg_page(reg_page), .reg_addr(reg_addr),
	.reg_wdata(reg_wdata), .reg_rdata(reg_rdata), .reg_rvalid(reg_rvalid), .over_temp_in(over_temp_in),
	.soft_shutdown_n(soft_shutdown_n), .scan_line_on(scan_line_on), .sink_current_scale(sink_current_scale));
`default_nettype wire

// >>> verif/tb_led_matrix_pwm_config.sv
// self-checking bench for registers, faults and scanning
`timescale 1ns/1ns
`default_nettype none
module tb_led_matrix_pwm_config;
	localparam int SCAN = 20;
	logic clk_sys, resetn, det_en, wr_en, rd_en, page, rvalid, ssd_n;
	logic [3:0] flt;
	logic [7:0] addr, wdata, rdata, v;
	logic [8:0] lines;
	logic [47:0] ch_on, dg;
	logic [47:0][7:0] scale;
	int errors = 0;
	int total_checks = 0;
	int cycles = 0;
	// short slot keeps the scan walks brief
	lmp_top #(.SCAN_CYCLES(SCAN)) dut_u (.clk_sys(clk_sys), .resetn(resetn), .reg_wr_en(wr_en),
		.reg_rd_en(rd_en), .reg_page(page), .reg_addr(addr), .reg_wdata(wdata), .reg_rdata(rdata),
		.reg_rvalid(rvalid), .over_temp_in(flt[3]), .over_current_in(flt[2]), .led_short_in(flt[1]),
		.led_open_in(flt[0]), .open_short_det_en(det_en), .soft_shutdown_n(ssd_n),
		.scan_line_on(lines), .sink_channel_on(ch_on), .sink_deghost(dg), .sink_current_scale(scale));
	lmp_host host_u (.clk_sys(clk_sys), .reg_wr_en(wr_en), .reg_rd_en(rd_en), .reg_page(page),
		.reg_addr(addr), .reg_wdata(wdata), .reg_rdata(rdata), .reg_rvalid(rvalid));
	// 250 MHz clock
	initial begin
		clk_sys = 1'b0;
		forever #2 clk_sys = ~clk_sys;
	end
	// hang guard, well above the five scan walks
	always @(posedge clk_sys) begin
		cycles <= cycles + 1;
		if (cycles == 40000) begin
			errors++;
			final_report;
		end
	end
	task chk(input string n, input logic [8:0] e, input logic [8:0] s);
		total_checks++;
		if (s !== e) begin
			$display("Error %s expected %h seen %h", n, e, s);
			errors++;
		end
	endtask : chk
	task rchk(input logic p, input logic [7:0] a, input logic [7:0] e);
		host_u.rd(p, a, v);
		chk("reg_rdata", e, v);
	endtask : rchk
	task t_defaults;
		logic [8:0] loc [8];
		int i;
		loc = '{9'h0F0, 9'h0F1, 9'h0F2, 9'h0F3, 9'h0EF, 9'h001, 9'h0EC, 9'h1B1};
		for (i = 0; i < 8; i++)
			rchk(loc[i][8], loc[i][7:0], 8'h00);
		chk("soft_shutdown_n", 9'h000, ssd_n);
		$display("test defaults done");
	endtask : t_defaults
	// entries are page, address, data written, value read back
	task t_regs;
		logic [24:0] tab [9];
		int i;
		tab = '{25'h0F1A5A5, 25'h0F23C3C, 25'h0F3C3C3, 25'h0EC7E7E, 25'h1B18181, 25'h1014242,
			25'h0ED1100, 25'h0EF1100, 25'h1B21100};
		for (i = 0; i < 9; i++)
			host_u.wr(tab[i][24], tab[i][23:16], tab[i][15:8]);
		for (i = 0; i < 9; i++)
			rchk(tab[i][24], tab[i][23:16], tab[i][7:0]);
		rchk(1'b0, 8'h01, 8'h00);
		chk("red scale", 9'h0A5, scale[45]);
		chk("green scale", 9'h03C, scale[1]);
		chk("blue scale", 9'h0C3, scale[47]);
		$display("test registers done");
	endtask : t_regs
	// flags are sticky: a read while the fault stands sets them again
	task t_faults;
		logic [3:0] f;
		logic [7:0] e;
		int i;
		for (i = 0; i < 5; i++) begin
			f = (i < 4) ? 4'h8 >> i : 4'h1;
			e = (i == 3) ? 8'h00 : {4'h0, f};
			@(posedge clk_sys);
			det_en <= (i == 4);
			flt <= f;
			repeat (5) @(posedge clk_sys);
			rchk(1'b0, lmp_pkg::ADDR_FAULT, e);
			flt <= 4'h0;
			repeat (5) @(posedge clk_sys);
			rchk(1'b0, lmp_pkg::ADDR_FAULT, e);
			rchk(1'b0, lmp_pkg::ADDR_FAULT, 8'h00);
		end
		$display("test faults done");
	endtask : t_faults
	task nxt(output logic [8:0] s);
		int i;
		for (i = 0; i < 4000 && lines != 9'h000; i++)
			@(posedge clk_sys);
		for (i = 0; i < 4000 && lines == 9'h000; i++)
			@(posedge clk_sys);
		s = lines;
	endtask : nxt
	// entries are config byte, then second and third lines expected
	task t_scan;
		logic [31:0] tab [5];
		logic [8:0] s;
		logic [47:0] o;
		int i, j, n;
		tab = '{32'h01002004, 32'h75002001, 32'h97004010, 32'hB3004001, 32'h81001001};
		host_u.wr(1'b0, 8'h01, 8'h09);
		for (i = 0; i < 5; i++) begin
			host_u.wr(1'b0, lmp_pkg::ADDR_CONFIG, 8'h00);
			repeat (3) @(posedge clk_sys);
			chk("scan_line_on", 9'h000, lines);
			host_u.wr(1'b0, lmp_pkg::ADDR_CONFIG, tab[i][31:24]);
			repeat (2) @(posedge clk_sys);
			chk("scan_line_on", 9'h001, lines);
			n = 0;
			for (j = 0; j < SCAN + 5; j++) begin
				@(posedge clk_sys);
				n += ch_on[0];
			end
			chk("on cycles", tab[i][26] ? 9'h009 : 9'h003, n[8:0]);
			chk("sink_deghost", 9'(!tab[i][25]), dg[0]);
			nxt(s);
			chk("scan_line_on", tab[i][20:12], s);
			nxt(s);
			chk("scan_line_on", tab[i][8:0], s);
		end
		host_u.wr(1'b0, lmp_pkg::ADDR_CONFIG, 8'h00);
		repeat (3) @(posedge clk_sys);
		host_u.wr(1'b0, lmp_pkg::ADDR_CONFIG, 8'hC5);
		s = 9'h000;
		o = '0;
		// direct mode: line one column drives every channel, only channel one has duty
		for (j = 0; j < 2100; j++) begin
			@(posedge clk_sys);
			s |= lines;
			o |= ch_on;
		end
		chk("scan_line_on", 9'h000, s);
		chk("sink_channel_on", 9'h001, o[8:0]);
		chk("soft_shutdown_n", 9'h001, ssd_n);
		$display("test scan done");
	endtask : t_scan
	task t_lock;
		host_u.wr(1'b0, lmp_pkg::ADDR_RED_SCALE, 8'h55);
		host_u.wr(1'b1, lmp_pkg::ADDR_SOFT_RESET, 8'h00);
		rchk(1'b0, lmp_pkg::ADDR_RED_SCALE, 8'h55);
		host_u.wr(1'b0, lmp_pkg::ADDR_CONFIG, 8'h08);
		host_u.wr(1'b1, lmp_pkg::ADDR_SOFT_RESET, 8'h00);
		rchk(1'b0, lmp_pkg::ADDR_RED_SCALE, 8'h00);
		rchk(1'b0, lmp_pkg::ADDR_CONFIG, 8'h00);
		rchk(1'b1, 8'hB1, 8'h00);
		$display("test lock done");
	endtask : t_lock
	task final_report;
		$display("checks %0d mismatches %0d", total_checks, errors);
		if (errors == 0 && total_checks > 0)
			$display("Simulation passed");
		else
			$display("Simulation failed");
		$finish;
	endtask : final_report
	// reset for 20 cycles, then the tests in turn
	initial begin
		resetn = 1'b0;
		det_en = 1'b0;
		flt = 4'h0;
		repeat (20) @(posedge clk_sys);
		resetn <= 1'b1;
		t_defaults;
		t_regs;
		t_faults;
		t_scan;
		t_lock;
		final_report;
	end
endmodule : tb_led_matrix_pwm_config
`default_nettype wire
